// *** hdl/vendor_status_pkg.sv ***
// Package with register offsets, field positions and reset values.
package vendor_status_pkg;
    localparam logic [7:0] STATUS_ADDR = 8'h83;
    localparam logic [7:0] LATCH_ADDR = 8'h84;
    localparam logic [7:0] CONTROL_ADDR = 8'h85;
    localparam int DET_W = 7;
    localparam int SOF_EN_BIT = 6;
    localparam int POL_BIT = 5;
    localparam int SINGLE_BIT = 4;
    localparam int IDGND_BIT = 3;
    localparam int VSEL_HI = 2;
    localparam int VSEL_W = 3;
    localparam logic [7:0] CONTROL_RESET = 8'h03;
    localparam logic [7:0] CONTROL_MASK = 8'h7F;
    localparam logic [7:0] READ_ZERO = 8'h00;
endpackage : vendor_status_pkg

// *** hdl/bit_sync.sv ***
// Two flip-flop synchroniser for a bundle of levels.
`timescale 1ns/1ns
module bit_sync #(
    parameter int W = 7
) (
    input wire logic clk_i, // Clock.
    input wire logic rst_i, // Asynchronous reset.
    input wire logic [W-1:0] async_i, // Asynchronous levels.
    output logic [W-1:0] sync_o // Synchronised levels.
);
    logic [W-1:0] meta_ff;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            meta_ff <= '0;
            sync_o <= '0;
        end else begin
            meta_ff <= async_i;
            sync_o <= meta_ff;
        end
    end
endmodule : bit_sync

// *** hdl/phy_vendor_status_latch_ctrl.sv ***
// Vendor status, change latch and pin/regulator control registers.
`timescale 1ns/1ns
module phy_vendor_status_latch_ctrl #(
    parameter int DET_W = vendor_status_pkg::DET_W
) (
    input wire logic clk_i, // ULPI clock.
    input wire logic rst_i, // Asynchronous reset, high.
    input wire logic reg_wr_i, // Register write strobe.
    input wire logic reg_rd_i, // Register read strobe.
    input wire logic [7:0] reg_addr_i, // Register address.
    input wire logic [7:0] reg_wdata_i, // Write data.
    output logic [7:0] reg_rdata_o, // Read data, one cycle after read.
    input wire logic supply_ok_monitor_i, // Supply monitor.
    input wire logic abnormal_stress_detect_i, // Stress detector.
    input wire logic id_pin_floating_i, // ID floating detector.
    input wire logic id_resistor_c_detect_i, // ID resistor C.
    input wire logic id_resistor_b_detect_i, // ID resistor B.
    input wire logic id_resistor_a_detect_i, // ID resistor A.
    input wire logic bus_session_valid_i, // Session valid.
    input wire logic [DET_W-1:0] change_mask_i, // Per-bit event enables.
    input wire logic low_power_i, // Low power mode level.
    input wire logic serial_mode_i, // Serial mode level.
    input wire logic clock_suspend_control_i, // Clock suspend setting.
    input wire logic peripheral_mode_i, // Device in peripheral mode.
    input wire logic sof_detect_i, // One-cycle frame-start pulse.
    output logic charge_pump_enable_pin_o, // Pump pin output value.
    output logic charge_pump_enable_pin_oe_o, // Pump pin drive enable.
    output logic id_ground_drive_o, // ID pin ground pull.
    output logic [2:0] regulator_voltage_select_o, // Regulator code.
    input wire logic pump_request_i // Functional pump enable request.
);
    logic [DET_W-1:0] raw_det;
    logic [DET_W-1:0] det_sync;
    logic [DET_W-1:0] det_prev_ff;
    logic [DET_W-1:0] latch_ff;
    logic [7:0] control_ff;
    logic low_power_prev_ff;
    logic serial_prev_ff;
    logic [DET_W-1:0] nxt_set;
    logic mode_clear;
    logic latch_read;
    logic pump_level;
    logic pin_level;
    logic pin_oe;

    assign raw_det = {supply_ok_monitor_i, abnormal_stress_detect_i,
                      id_pin_floating_i, id_resistor_c_detect_i,
                      id_resistor_b_detect_i, id_resistor_a_detect_i,
                      bus_session_valid_i};

    bit_sync #(.W(DET_W)) u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .async_i(raw_det),
        .sync_o(det_sync)
    );

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            det_prev_ff <= '0;
            low_power_prev_ff <= 1'b0;
            serial_prev_ff <= 1'b0;
        end else begin
            det_prev_ff <= det_sync;
            low_power_prev_ff <= low_power_i;
            serial_prev_ff <= serial_mode_i;
        end
    end

    assign nxt_set = (det_sync ^ det_prev_ff) & change_mask_i;
    // Serial entry clears regardless of the clock suspend setting.
    assign mode_clear = (low_power_i & ~low_power_prev_ff)
                      | (serial_mode_i & ~serial_prev_ff);
    assign latch_read = reg_rd_i
                        && reg_addr_i == vendor_status_pkg::LATCH_ADDR;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            latch_ff <= '0;
        end else if (latch_read || mode_clear) begin
            latch_ff <= nxt_set;
        end else begin
            latch_ff <= latch_ff | nxt_set;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            control_ff <= vendor_status_pkg::CONTROL_RESET;
        end else if (reg_wr_i &&
                     reg_addr_i == vendor_status_pkg::CONTROL_ADDR) begin
            control_ff <= reg_wdata_i
                          & vendor_status_pkg::CONTROL_MASK;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            reg_rdata_o <= vendor_status_pkg::READ_ZERO;
        end else if (reg_rd_i) begin
            case (reg_addr_i)
                vendor_status_pkg::STATUS_ADDR: begin
                    reg_rdata_o <= {1'b0, det_sync};
                end
                vendor_status_pkg::LATCH_ADDR: begin
                    reg_rdata_o <= {1'b0, latch_ff};
                end
                vendor_status_pkg::CONTROL_ADDR: begin
                    reg_rdata_o <= control_ff;
                end
                default: begin
                    reg_rdata_o <= vendor_status_pkg::READ_ZERO;
                end
            endcase
        end
    end

    // The debug frame-start output replaces the functional pump request.
    always_comb begin
        if (control_ff[vendor_status_pkg::SOF_EN_BIT]) begin
            pump_level = peripheral_mode_i & sof_detect_i;
        end else begin
            pump_level = pump_request_i;
        end
        if (!control_ff[vendor_status_pkg::SINGLE_BIT]) begin
            pin_level = pump_level;
            pin_oe = 1'b1;
        end else if (control_ff[vendor_status_pkg::POL_BIT]) begin
            pin_level = 1'b1;
            pin_oe = pump_level;
        end else begin
            pin_level = 1'b0;
            pin_oe = pump_level;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            charge_pump_enable_pin_o <= 1'b0;
            charge_pump_enable_pin_oe_o <= 1'b1;
            id_ground_drive_o <= 1'b0;
            regulator_voltage_select_o <= vendor_status_pkg::CONTROL_RESET[
                vendor_status_pkg::VSEL_W-1:0];
        end else begin
            charge_pump_enable_pin_o <= pin_level;
            charge_pump_enable_pin_oe_o <= pin_oe;
            id_ground_drive_o <=
                control_ff[vendor_status_pkg::IDGND_BIT];
            regulator_voltage_select_o <=
                control_ff[vendor_status_pkg::VSEL_HI:0];
        end
    end

    status_live_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        reg_rd_i && reg_addr_i == vendor_status_pkg::STATUS_ADDR |=>
        reg_rdata_o == {1'b0, $past(det_sync)})
        else $error("status read mismatch");
    status_rsvd_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        $past(reg_rd_i) && $past(reg_addr_i) == vendor_status_pkg::STATUS_ADDR
        |-> !reg_rdata_o[DET_W])
        else $error("status bit 7 set");
    latch_set_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        |nxt_set |=> (latch_ff & $past(nxt_set)) == $past(nxt_set))
        else $error("latch not set");
    masked_none_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        !latch_read && !mode_clear |=>
        (latch_ff & ~$past(latch_ff) & ~$past(change_mask_i)) == '0)
        else $error("masked change latched");
    read_clear_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        latch_read |=> latch_ff == $past(nxt_set))
        else $error("read did not clear");
    mode_clear_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        $rose(low_power_i) || $rose(serial_mode_i) |=>
        latch_ff == $past(nxt_set))
        else $error("mode entry did not clear");
    lp_clear_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        $rose(low_power_i) |=> latch_ff == $past(nxt_set))
        else $error("low power entry did not clear");
    idgnd_out_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        ##1 id_ground_drive_o ==
        $past(control_ff[vendor_status_pkg::IDGND_BIT]))
        else $error("id ground mismatch");
    vsel_write_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        reg_wr_i && reg_addr_i == vendor_status_pkg::CONTROL_ADDR |=> ##1
        regulator_voltage_select_o ==
        $past(reg_wdata_i[vendor_status_pkg::VSEL_HI:0], 2))
        else $error("regulator code mismatch");
    cmos_drive_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        !control_ff[vendor_status_pkg::SINGLE_BIT] |=>
        charge_pump_enable_pin_oe_o)
        else $error("push-pull not driven");
    single_pol_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        control_ff[vendor_status_pkg::SINGLE_BIT] && pin_oe |=>
        charge_pump_enable_pin_o ==
        $past(control_ff[vendor_status_pkg::POL_BIT]))
        else $error("single transistor polarity");
    sof_pulse_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        control_ff[vendor_status_pkg::SOF_EN_BIT] &&
        !control_ff[vendor_status_pkg::SINGLE_BIT] |=>
        charge_pump_enable_pin_o == $past(peripheral_mode_i & sof_detect_i))
        else $error("frame pulse mismatch");
    ctrl_rsvd_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        reg_rd_i && reg_addr_i == vendor_status_pkg::CONTROL_ADDR |=>
        !reg_rdata_o[DET_W])
        else $error("control bit 7 set");
endmodule : phy_vendor_status_latch_ctrl

// *** tb/link_reg_model.sv ***
// Link controller model that issues register reads and writes.
`timescale 1ns/1ns
module link_reg_model (
    input wire logic clk_i, // Clock.
    input wire logic [7:0] rdata_i, // Read data from the device.
    output logic wr_o, // Write strobe.
    output logic rd_o, // Read strobe.
    output logic [7:0] addr_o, // Address.
    output logic [7:0] wdata_o // Write data.
);
    initial begin
        wr_o = 1'b0;
        rd_o = 1'b0;
        addr_o = 8'h00;
        wdata_o = 8'h00;
    end
    // The frame-start bit is written only where the bench asks; after the strobe, wdata_o carries ~d with wr_o low.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        wr_o <= 1'b1;
        addr_o <= a;
        wdata_o <= d;
        @(posedge clk_i);
        wr_o <= 1'b0;
        addr_o <= ~a;
        wdata_o <= ~d;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_i);
        rd_o <= 1'b1;
        addr_o <= a;
        @(posedge clk_i);
        rd_o <= 1'b0;
        addr_o <= ~a;
        #1;
        d = rdata_i;
    endtask : rd
endmodule : link_reg_model

// *** tb/test_phy_vendor_status_latch_ctrl.sv ***
// Self-checking bench for the vendor status, latch and control registers.
`timescale 1ns/1ns
module test_phy_vendor_status_latch_ctrl;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wr, rd, lp = 1'b0, ser = 1'b0, susp = 1'b0, per = 1'b0;
    logic sof = 1'b0, req = 1'b0, pin, oe, idg;
    logic [7:0] addr, wdata, rdata, d;
    logic [6:0] det = 7'h00, mask = 7'h00;
    logic [2:0] vsel;
    int failures = 0;
    int n_tests = 0;
    logic [4:0] pt [8] = '{5'b00111, 5'b00001, 5'b10111, 5'b10001,
        5'b11111, 5'b11000, 5'b01101, 5'b01000};
    always #4 clk_i = ~clk_i;
    link_reg_model u_link (.clk_i(clk_i), .rdata_i(rdata), .wr_o(wr),
        .rd_o(rd), .addr_o(addr), .wdata_o(wdata));
    phy_vendor_status_latch_ctrl u_dut (.clk_i(clk_i), .rst_i(rst_i),
        .reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_rdata_o(rdata),
        .supply_ok_monitor_i(det[6]), .abnormal_stress_detect_i(det[5]),
        .id_pin_floating_i(det[4]), .id_resistor_c_detect_i(det[3]),
        .id_resistor_b_detect_i(det[2]), .id_resistor_a_detect_i(det[1]),
        .bus_session_valid_i(det[0]), .change_mask_i(mask),
        .low_power_i(lp), .serial_mode_i(ser),
        .clock_suspend_control_i(susp), .peripheral_mode_i(per),
        .sof_detect_i(sof), .charge_pump_enable_pin_o(pin),
        .charge_pump_enable_pin_oe_o(oe), .id_ground_drive_o(idg),
        .regulator_voltage_select_o(vsel), .pump_request_i(req));
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
    endtask : cyc
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
        u_link.rd(a, d);
        chk(d, exp);
    endtask : rdchk
    task automatic t_status();
        rdchk(vendor_status_pkg::CONTROL_ADDR, 8'h03);
        chk({4'h0, idg, vsel}, 8'h03);
        @(posedge clk_i) det <= 7'h55;
        cyc(4);
        rdchk(vendor_status_pkg::STATUS_ADDR, 8'h55);
        u_link.wr(vendor_status_pkg::STATUS_ADDR, 8'hFF);
        @(posedge clk_i) det <= 7'h2A;
        cyc(4);
        rdchk(vendor_status_pkg::STATUS_ADDR, 8'h2A);
        rdchk(8'h90, vendor_status_pkg::READ_ZERO);
        $display("status test done");
    endtask : t_status
    task automatic t_latch();
        @(posedge clk_i) mask <= 7'h04;
        rdchk(vendor_status_pkg::LATCH_ADDR, 8'h00);
        @(posedge clk_i) det <= det ^ 7'h0C;
        cyc(5);
        rdchk(vendor_status_pkg::LATCH_ADDR, 8'h04);
        rdchk(vendor_status_pkg::LATCH_ADDR, 8'h00);
        @(posedge clk_i) det <= det ^ 7'h04;
        cyc(5);
        @(posedge clk_i) lp <= 1'b1;
        cyc(3);
        rdchk(vendor_status_pkg::LATCH_ADDR, 8'h00);
        @(posedge clk_i) det <= det ^ 7'h04;
        susp <= 1'b1;
        cyc(5);
        @(posedge clk_i) ser <= 1'b1;
        cyc(3);
        rdchk(vendor_status_pkg::LATCH_ADDR, 8'h00);
        // The set lands on the same edge as the clearing read.
        @(posedge clk_i) det <= det ^ 7'h04;
        cyc(1);
        rdchk(vendor_status_pkg::LATCH_ADDR, 8'h00);
        rdchk(vendor_status_pkg::LATCH_ADDR, 8'h04);
        $display("latch test done");
    endtask : t_latch
    task automatic t_control();
        for (int c = 0; c < 8; c++) begin
            u_link.wr(vendor_status_pkg::CONTROL_ADDR, 8'h88 | 8'(c));
            rdchk(vendor_status_pkg::CONTROL_ADDR, 8'h08 | 8'(c));
            chk({4'h0, idg, vsel}, 8'h08 | 8'(c));
        end
        foreach (pt[i]) begin
            u_link.wr(vendor_status_pkg::CONTROL_ADDR,
                {2'b00, pt[i][4:3], 4'h3});
            @(posedge clk_i) req <= pt[i][2];
            cyc(3);
            chk({6'h0, oe, pin & oe},
                {6'h0, pt[i][0], pt[i][1]});
        end
        $display("control test done");
    endtask : t_control
    task automatic t_frame(input logic p, input logic exp);
        logic seen;
        seen = 1'b0;
        @(posedge clk_i) req <= 1'b0;
        per <= p;
        u_link.wr(vendor_status_pkg::CONTROL_ADDR, 8'h43);
        cyc(3);
        @(posedge clk_i) sof <= 1'b1;
        @(posedge clk_i) sof <= 1'b0;
        repeat (4) begin
            @(posedge clk_i);
            seen = seen | (pin === 1'b1);
        end
        chk({7'h0, seen}, {7'h0, exp});
        $display("frame test done");
    endtask : t_frame
    task automatic test_done();
        $display("comparisons %0d, mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : test_done
    initial begin
        #100000;
        failures++;
        test_done();
    end
    initial begin
        cyc(16);
        @(posedge clk_i) rst_i <= 1'b0;
        t_status();
        t_latch();
        t_control();
        t_frame(1'b1, 1'b1);
        t_frame(1'b0, 1'b0);
        test_done();
    end
endmodule : test_phy_vendor_status_latch_ctrl
